// ---- rtl/psfm_consts.svh ----
/*
 power-safe fault monitor constants and register map.
 assumes inclusion by bare name from rtl files; definitions only.
*/
`ifndef PSFM_CONSTS_SVH
`define PSFM_CONSTS_SVH
`define PSFM_ADDR_CTRL    8'h00
`define PSFM_ADDR_STATUS  8'h04
`define PSFM_ADDR_IRQ_ST  8'h08
`define PSFM_ADDR_IRQ_MSK 8'h0C
`define PSFM_ADDR_FAULTS  8'h10
// ctrl register bits
`define PSFM_CTRL_CPU_REARM 0
// irq bits
`define PSFM_IRQ_W        5
`define PSFM_IRQ_PWRFAIL  0
`define PSFM_IRQ_NONRED   1
`define PSFM_IRQ_THROT    2
`define PSFM_IRQ_LINKLOST 3
`define PSFM_IRQ_LAMP     4
`define PSFM_IRQ_RST      5'h00
`define PSFM_LOW_RANGE_VAC 200
`endif

// ---- rtl/psfm_pkg.sv ----
/*
 power-safe fault monitor types.
 assumes psfm_consts.svh is included beside it.
*/
package psfm_pkg;
   typedef enum logic [1:0]
   {
      PSFM_REDUNDANT = 2'b00,
      PSFM_NONRED    = 2'b01,
      PSFM_THROTTLED = 2'b10
   } psfm_state_t;
   // one-cycle event pulses, grouped
   typedef struct packed
   {
      logic pwr_fail;
      logic nonred;
      logic throt;
      logic link_lost;
      logic lamp;
   } psfm_evt_t;
endpackage

// ---- rtl/psfm_sync.sv ----
/*
 three-flop input synchroniser with agreement filter.
 assumes async inputs; the output changes only when flops two and three agree.
*/
`timescale 1ns/1ps
`default_nettype none
module psfm_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] s1_r, s2_r, s3_r, q_r;
   logic [W-1:0] q_nxt;

   // --------------------------------------------------
   // filter: take each bit only when stages agree
   // --------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < W; i++)
         q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q_r  <= '0;
      end
      else
      begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r  <= q_nxt;
      end
   end
   assign q = q_r;
endmodule
`default_nettype wire

// ---- rtl/psfm_top.sv ----
/*
 power-safe and fault-lamp monitor with apb register access.
 assumes board pins are asynchronous and pass the three-flop filter;
 apb master on pclk; zero-wait-state slave.
*/
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "psfm_consts.svh"
module psfm_top
   import psfm_pkg::*;
#(
   parameter int N_PWR = 4,
   parameter int N_FAN = 8,
   parameter int N_CPU = 4
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output var  logic [31:0]      prdata,
   output var  logic             pready,
   output var  logic             pslverr,
   input  wire logic [N_PWR-1:0] pwr_good,
   input  wire logic             supply_overload_flag,
   input  wire logic [1:0]       supply_ok,
   input  wire logic             range_low,
   input  wire logic             telemetry_fail,
   input  wire logic [N_FAN-1:0] fan_low_crit,
   input  wire logic [N_CPU-1:0] cpu_cfg_err,
   input  wire logic [N_CPU-1:0] cpu_disabled,
   input  wire logic [1:0]       link_up,
   input  wire logic             sys_dc_on,
   input  wire logic             sys_reset,
   output var  logic             beep_req,
   output var  logic             status_lamp_crit,
   output var  logic             supply_utilization_lamp,
   output var  logic             cpu_throttle,
   output var  logic [N_FAN-1:0] fan_lamp,
   output var  logic [N_CPU-1:0] cpu_lamp,
   output var  logic             link_lost,
   output var  logic             irq
);
   localparam int NI = N_PWR + 5 + N_FAN + 2 * N_CPU + 2 + 2;

   // --------------------------------------------------
   // pin synchronisers
   // --------------------------------------------------
   logic [NI-1:0] raw_in, syn;
   assign raw_in = {pwr_good, supply_overload_flag, supply_ok, range_low, telemetry_fail,
                    fan_low_crit, cpu_cfg_err, cpu_disabled, link_up, sys_dc_on, sys_reset};
   psfm_sync #(.W(NI)) u_sync (.clk(pclk), .rst_n(presetn), .d(raw_in), .q(syn));

   logic [N_PWR-1:0] pg_s;
   logic             ovl_s, rng_s, tfail_s, dcon_s, sysrst_s;
   logic [1:0]       ok_s, link_s;
   logic [N_FAN-1:0] fan_s;
   logic [N_CPU-1:0] cerr_s, cdis_s;
   assign {pg_s, ovl_s, ok_s, rng_s, tfail_s, fan_s, cerr_s, cdis_s, link_s, dcon_s,
           sysrst_s} = syn;

   // --------------------------------------------------
   // state registers
   // --------------------------------------------------
   psfm_state_t          st_r, st_nxt;
   logic [N_PWR-1:0]     pg_r, pg_nxt;
   logic [1:0]           link_r, link_nxt;
   logic                 dcon_r, dcon_nxt;
   logic                 lost_r, lost_nxt;
   logic [N_FAN-1:0]     fan_r, fan_nxt;
   logic [N_CPU-1:0]     cpu_r, cpu_nxt;
   logic                 crit_r, crit_nxt;
   logic                 beep_r, beep_nxt;
   logic                 util_r, util_nxt;
   logic                 thr_r, thr_nxt;
   logic [`PSFM_IRQ_W-1:0] ist_r, ist_nxt, imsk_r, imsk_nxt;
   logic                 irq_r, irq_nxt;
   logic [31:0]          rd_r, rd_nxt;
   logic                 rearm_r, rearm_nxt;
   logic                 ps_active;
   logic                 one_supply;
   psfm_evt_t            evt;

   // apb access strobes; slave answers in the access phase
   logic acc_wr, acc_rd;
   assign acc_wr = psel & penable & pwrite;
   assign acc_rd = psel & ~penable & ~pwrite;

   // decode: is addr equal to a register offset
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // --------------------------------------------------
   // power-safe, lamps and link next state
   // --------------------------------------------------
   always_comb
   begin
      // telemetry loss disables power-safe; only below the low range
      ps_active  = rng_s & ~tfail_s;
      one_supply = (ok_s != 2'b11);
      st_nxt = PSFM_REDUNDANT;
      // priority: throttled, then non-redundant, then redundant
      if (ps_active && one_supply && ovl_s)
         st_nxt = PSFM_THROTTLED;
      else if (one_supply || (ps_active && ovl_s))
         st_nxt = PSFM_NONRED;
      else
         st_nxt = PSFM_REDUNDANT;
      thr_nxt  = (st_nxt == PSFM_THROTTLED);
      util_nxt = ps_active & ovl_s;
      pg_nxt   = pg_s;
      // a drop on any power-good latches the critical lamp
      crit_nxt = crit_r | (|(pg_r & ~pg_s));
      beep_nxt = |(pg_r & ~pg_s);
      dcon_nxt = dcon_s;
      // fans rearm on dc power-on edge and system reset, set wins
      if (sysrst_s || (dcon_s && !dcon_r))
         fan_nxt = fan_s;
      else
         fan_nxt = fan_r | fan_s;
      // processor lamps ignore power-on and reset; explicit rearm only
      cpu_nxt = (rearm_r ? '0 : cpu_r) | cerr_s | cdis_s;
      link_nxt = link_s;
      // only the two embedded channels feed link-lost
      lost_nxt = lost_r;
      if (|(link_r & ~link_s))
         lost_nxt = 1'b1;
      else if (|(~link_r & link_s))
         lost_nxt = 1'b0;
      // entry pulses only
      evt.pwr_fail  = beep_nxt;
      evt.nonred    = (st_nxt == PSFM_NONRED) && (st_r != PSFM_NONRED);
      evt.throt     = (st_nxt == PSFM_THROTTLED) && (st_r != PSFM_THROTTLED);
      evt.link_lost = lost_nxt & ~lost_r;
      evt.lamp      = |((fan_nxt & ~fan_r)) | |(cpu_nxt & ~cpu_r);
   end

   // --------------------------------------------------
   // register file next state
   // --------------------------------------------------
   always_comb
   begin
      imsk_nxt  = imsk_r;
      rearm_nxt = 1'b0;
      ist_nxt   = ist_r;
      if (acc_wr && hit(paddr, `PSFM_ADDR_IRQ_MSK))
         imsk_nxt = pwdata[`PSFM_IRQ_W-1:0];
      if (acc_wr && hit(paddr, `PSFM_ADDR_CTRL))
         rearm_nxt = pwdata[`PSFM_CTRL_CPU_REARM];
      if (acc_wr && hit(paddr, `PSFM_ADDR_IRQ_ST))
         ist_nxt = ist_r & ~pwdata[`PSFM_IRQ_W-1:0];
      // a new event beats a clear in the same cycle; each event goes to its own bit,
      // since the packing order of the event group is not the status layout
      ist_nxt[`PSFM_IRQ_PWRFAIL]  = ist_nxt[`PSFM_IRQ_PWRFAIL] | evt.pwr_fail;
      ist_nxt[`PSFM_IRQ_NONRED]   = ist_nxt[`PSFM_IRQ_NONRED] | evt.nonred;
      ist_nxt[`PSFM_IRQ_THROT]    = ist_nxt[`PSFM_IRQ_THROT] | evt.throt;
      ist_nxt[`PSFM_IRQ_LINKLOST] = ist_nxt[`PSFM_IRQ_LINKLOST] | evt.link_lost;
      ist_nxt[`PSFM_IRQ_LAMP]     = ist_nxt[`PSFM_IRQ_LAMP] | evt.lamp;
      irq_nxt = |(ist_nxt & imsk_nxt);
      rd_nxt = rd_r;
      if (acc_rd)
      begin
         case (paddr)
            `PSFM_ADDR_STATUS:  rd_nxt = {24'h000000, lost_r, util_r, thr_r, crit_r,
                                          ok_s, 2'(st_r)};
            `PSFM_ADDR_IRQ_ST:  rd_nxt = 32'(ist_r);
            `PSFM_ADDR_IRQ_MSK: rd_nxt = 32'(imsk_r);
            `PSFM_ADDR_FAULTS:  rd_nxt = {16'h0000, 8'(cpu_r), 8'(fan_r)};
            default:            rd_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r    <= PSFM_REDUNDANT;
         pg_r    <= '0;
         link_r  <= 2'b00;
         dcon_r  <= 1'b0;
         lost_r  <= 1'b0;
         fan_r   <= '0;
         cpu_r   <= '0;
         crit_r  <= 1'b0;
         beep_r  <= 1'b0;
         util_r  <= 1'b0;
         thr_r   <= 1'b0;
         ist_r   <= `PSFM_IRQ_RST;
         imsk_r  <= `PSFM_IRQ_RST;
         irq_r   <= 1'b0;
         rd_r    <= 32'h00000000;
         rearm_r <= 1'b0;
      end
      else
      begin
         st_r    <= st_nxt;
         pg_r    <= pg_nxt;
         link_r  <= link_nxt;
         dcon_r  <= dcon_nxt;
         lost_r  <= lost_nxt;
         fan_r   <= fan_nxt;
         cpu_r   <= cpu_nxt;
         crit_r  <= crit_nxt;
         beep_r  <= beep_nxt;
         util_r  <= util_nxt;
         thr_r   <= thr_nxt;
         ist_r   <= ist_nxt;
         imsk_r  <= imsk_nxt;
         irq_r   <= irq_nxt;
         rd_r    <= rd_nxt;
         rearm_r <= rearm_nxt;
      end
   end

   // outputs straight from flops, pready and pslverr tied off; fan/cpu bits beyond 8 are not readable
   assign prdata                  = rd_r;
   assign pready                  = 1'b1;
   assign pslverr                 = 1'b0;
   assign beep_req                = beep_r;
   assign status_lamp_crit        = crit_r;
   assign supply_utilization_lamp = util_r;
   assign cpu_throttle            = thr_r;
   assign fan_lamp                = fan_r;
   assign cpu_lamp                = cpu_r;
   assign link_lost               = lost_r;
   assign irq                     = irq_r;

   // --------------------------------------------------
   // checks
   // --------------------------------------------------
   chk_pg_drop_crit: assert property (@(posedge pclk) disable iff (!presetn)
      (|(pg_r & ~pg_s)) |=> (status_lamp_crit && beep_req))
      else $error("power-good drop did not light critical lamp");
   chk_range_gate: assert property (@(posedge pclk) disable iff (!presetn)
      (!rng_s) |=> !supply_utilization_lamp)
      else $error("utilization lamp lit above low range");
   chk_redundant_ok: assert property (@(posedge pclk) disable iff (!presetn)
      (ok_s != 2'b11 || (rng_s && !tfail_s && ovl_s)) |=> (st_r != PSFM_REDUNDANT))
      else $error("redundant without two supplies and a clear overload flag");
   chk_one_nonred: assert property (@(posedge pclk) disable iff (!presetn)
      (ok_s != 2'b11) |=> (st_r != PSFM_REDUNDANT))
      else $error("single supply stayed redundant");
   chk_util_lamp: assert property (@(posedge pclk) disable iff (!presetn)
      (rng_s && !tfail_s && ovl_s) |=> supply_utilization_lamp)
      else $error("utilization lamp not lit");
   chk_throttle: assert property (@(posedge pclk) disable iff (!presetn)
      (rng_s && !tfail_s && ovl_s && ok_s != 2'b11) |=> cpu_throttle)
      else $error("throttle not applied");
   chk_tel_fail: assert property (@(posedge pclk) disable iff (!presetn)
      tfail_s |=> !cpu_throttle)
      else $error("throttle with telemetry failure");
   chk_fan_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (fan_r[0] && !sysrst_s && !(dcon_s && !dcon_r)) |=> fan_lamp[0])
      else $error("fan lamp dropped without rearm");
   chk_fan_rearm: assert property (@(posedge pclk) disable iff (!presetn)
      (sysrst_s && !fan_s[0]) |=> !fan_lamp[0])
      else $error("fan lamp not rearmed");
   chk_cpu_keep: assert property (@(posedge pclk) disable iff (!presetn)
      (cpu_r[0] && !rearm_r) |=> cpu_lamp[0])
      else $error("cpu lamp cleared without rearm");
   chk_link_lost: assert property (@(posedge pclk) disable iff (!presetn)
      (|(link_r & ~link_s)) |=> link_lost)
      else $error("link loss not flagged");
   chk_link_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (link_lost && !(|(~link_r & link_s))) |=> link_lost)
      else $error("link-lost cleared without new link");
   chk_nonred_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      evt.nonred |=> !evt.nonred)
      else $error("non-redundant event not one cycle");
   chk_range_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (!rng_s && ok_s == 2'b11) |=> (st_r == PSFM_REDUNDANT))
      else $error("overload flag evaluated above low range");
   chk_tel_util: assert property (@(posedge pclk) disable iff (!presetn)
      tfail_s |=> !supply_utilization_lamp)
      else $error("utilization lamp with telemetry failure");
   chk_cpu_latch: assert property (@(posedge pclk) disable iff (!presetn)
      (cerr_s[0] || cdis_s[0]) |=> cpu_lamp[0])
      else $error("cpu fault did not light lamp");

   // --------------------------------------------------
   // event log checks
   // --------------------------------------------------
   // each event must land on the status bit that software reads for it
   chk_pwr_event: assert property (@(posedge pclk) disable iff (!presetn)
      beep_req |-> ist_r[`PSFM_IRQ_PWRFAIL])
      else $error("power-good drop not logged");
   chk_nonred_event: assert property (@(posedge pclk) disable iff (!presetn)
      evt.nonred |=> ist_r[`PSFM_IRQ_NONRED])
      else $error("non-redundant entry not logged");
   chk_throt_event: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(cpu_throttle) |-> ist_r[`PSFM_IRQ_THROT])
      else $error("throttle entry not logged");
   chk_link_event: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(link_lost) |-> ist_r[`PSFM_IRQ_LINKLOST])
      else $error("link loss not logged");
   chk_lamp_event: assert property (@(posedge pclk) disable iff (!presetn)
      (|(fan_s & ~fan_r)) |=> ist_r[`PSFM_IRQ_LAMP])
      else $error("new fan lamp not logged");
   chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      irq == (|(ist_r & imsk_r)))
      else $error("interrupt pin disagrees with masked status");
endmodule
`default_nettype wire

// ---- verif/psfm_board.sv ----
/*
 board-side model: the supplies and the board logic device.
 assumes the bench sets supply health and the utilization level.
*/
`timescale 1ns/1ps
`default_nettype none
module psfm_board #(
   parameter int SAFE_POINT = 8'hC0
) (
   input  wire logic [7:0] util,
   input  wire logic [1:0] sup_up,
   output var  logic       supply_overload_flag,
   output var  logic [1:0] supply_ok
);
   // flag rises at the safe point itself, not one step above it
   always_comb
   begin
      supply_overload_flag = (util >= SAFE_POINT[7:0]);
      supply_ok            = sup_up;
   end
endmodule
`default_nettype wire

// ---- verif/psfm_top_test.sv ----
/*
 self-checking bench for the power-safe fault monitor.
 assumes a zero-wait apb slave and about five cycles from pin to output.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psfm_consts.svh"
module psfm_top_test
   import psfm_pkg::*;
;
   typedef struct packed
   {
      logic [1:0]  sup;
      logic        hi;
      logic        rl;
      logic        tf;
      psfm_state_t st;
      logic        thr;
      logic        lamp;
   } psfm_row_t;
   // ------------------------------------------------
   // signals and instances
   // ------------------------------------------------
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ovl;
   logic [7:0]  paddr, util, fan_low_crit, fan_lamp;
   logic [31:0] pwdata, prdata, rd;
   logic        range_low, telemetry_fail, sys_dc_on, sys_reset, beep_req;
   logic        crit, util_lamp, cpu_throttle, link_lost, irq;
   logic [3:0]  pwr_good, cpu_cfg_err, cpu_disabled, cpu_lamp;
   logic [1:0]  sup_up, supply_ok, link_up;
   int          mismatches, check_count, i, n;
   // util is one below or exactly at the safe point
   localparam psfm_row_t ROWS [7] = '{
      '{2'h3, 1'h0, 1'h1, 1'h0, PSFM_REDUNDANT, 1'h0, 1'h0},
      '{2'h3, 1'h1, 1'h1, 1'h0, PSFM_NONRED,    1'h0, 1'h1},
      '{2'h3, 1'h1, 1'h0, 1'h0, PSFM_REDUNDANT, 1'h0, 1'h0},
      '{2'h1, 1'h0, 1'h1, 1'h0, PSFM_NONRED,    1'h0, 1'h0},
      '{2'h1, 1'h1, 1'h1, 1'h0, PSFM_THROTTLED, 1'h1, 1'h1},
      '{2'h1, 1'h1, 1'h1, 1'h1, PSFM_NONRED,    1'h0, 1'h0},
      '{2'h2, 1'h1, 1'h0, 1'h0, PSFM_NONRED,    1'h0, 1'h0}};
   psfm_board i_psfm_board
   (
      .util, .sup_up, .supply_overload_flag (ovl), .supply_ok
   );
   psfm_top i_psfm_top
   (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .pwr_good, .supply_overload_flag (ovl), .supply_ok,
      .range_low, .telemetry_fail, .fan_low_crit, .cpu_cfg_err, .cpu_disabled,
      .link_up, .sys_dc_on, .sys_reset, .beep_req, .status_lamp_crit (crit),
      .supply_utilization_lamp (util_lamp), .cpu_throttle, .fan_lamp, .cpu_lamp,
      .link_lost, .irq
   );
   // free-running 250 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // ------------------------------------------------
   // tasks
   // ------------------------------------------------
   task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge pclk);
   endtask
   // one apb transfer; the wait for pready is bounded so a hang ends the run
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      rd = prdata;
      if (pready !== 1'b1)
      begin
         mismatches++;
         end_of_test();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, util} = '0;
      {telemetry_fail, sys_dc_on, sys_reset, fan_low_crit, cpu_cfg_err, cpu_disabled} = '0;
      {mismatches, check_count} = '0;
      sup_up    = 2'h3;
      range_low = 1'b1;
      pwr_good  = 4'hF;
      link_up   = 2'h3;
      tick(4);
      cmp("reset outputs", {beep_req, crit, util_lamp, cpu_throttle, link_lost, irq, fan_lamp,
          cpu_lamp}, 32'h0);
      presetn <= 1'b1;
      tick(8);
      apb(1'b1, `PSFM_ADDR_IRQ_MSK, 32'h0000_0002);
      for (i = 0; i < 7; i++)
      begin
         sup_up         <= ROWS[i].sup;
         util           <= ROWS[i].hi ? 8'hC0 : 8'hBF;
         range_low      <= ROWS[i].rl;
         telemetry_fail <= ROWS[i].tf;
         tick(8);
         apb(1'b0, `PSFM_ADDR_STATUS, 32'h0);
         cmp("state", {rd[6:5], rd[1:0]}, {ROWS[i].lamp, ROWS[i].thr, ROWS[i].st});
         cmp("lamp pins", {util_lamp, cpu_throttle}, {ROWS[i].lamp, ROWS[i].thr});
      end
      cmp("irq pin", irq, 32'h1);
      apb(1'b0, `PSFM_ADDR_IRQ_ST, 32'h0);
      cmp("entry events", rd[3:0], 32'h6);
      apb(1'b1, `PSFM_ADDR_IRQ_ST, 32'h0000_001F);
      apb(1'b0, `PSFM_ADDR_IRQ_ST, 32'h0);
      cmp("events cleared", {irq, rd[4:0]}, 32'h0);
      $display("power-safe table done");
      // a dropped power-good gives exactly one beep pulse
      pwr_good <= 4'hE;
      n = 0;
      repeat (12)
      begin
         @(posedge pclk);
         n += beep_req;
      end
      cmp("beep pulses", n, 32'h1);
      pwr_good <= 4'hF;
      tick(8);
      apb(1'b0, `PSFM_ADDR_IRQ_ST, 32'h0);
      cmp("fail event masked", {crit, irq, rd[0]}, 32'h5);
      $display("power-good test done");
      fan_low_crit <= 8'h81;
      cpu_cfg_err  <= 4'h1;
      cpu_disabled <= 4'h8;
      tick(8);
      {fan_low_crit, cpu_cfg_err, cpu_disabled} <= '0;
      tick(8);
      apb(1'b0, `PSFM_ADDR_FAULTS, 32'h0);
      cmp("faults reg", rd, 32'h0000_0981);
      sys_reset <= 1'b1;
      tick(8);
      sys_reset <= 1'b0;
      tick(8);
      cmp("lamps after reset", {fan_lamp, cpu_lamp}, 32'h009);
      fan_low_crit <= 8'h02;
      tick(8);
      fan_low_crit <= 8'h00;
      tick(8);
      cmp("fan relatched", fan_lamp, 32'h02);
      sys_dc_on <= 1'b1;
      tick(8);
      cmp("lamps after power-on", {fan_lamp, cpu_lamp}, 32'h009);
      apb(1'b1, `PSFM_ADDR_CTRL, 32'h0000_0001);
      tick(8);
      cmp("lamps after rearm", cpu_lamp, 32'h0);
      $display("lamp test done");
      // second channel drops, both down, then the second one comes up fresh
      link_up <= 2'h1;
      tick(8);
      cmp("link lost set", link_lost, 32'h1);
      link_up <= 2'h0;
      tick(8);
      cmp("link lost held", link_lost, 32'h1);
      link_up <= 2'h2;
      tick(8);
      cmp("link lost cleared", link_lost, 32'h0);
      apb(1'b0, `PSFM_ADDR_IRQ_ST, 32'h0);
      cmp("late events", rd[4:0], 32'h19);
      apb(1'b0, 8'h1C, 32'h0);
      cmp("unmapped read", rd, 32'h0);
      cmp("bus error", pslverr, 32'h0);
      $display("link test done");
      presetn <= 1'b0;
      tick(2);
      cmp("crit after reset", crit, 32'h0);
      presetn <= 1'b1;
      tick(8);
      apb(1'b0, `PSFM_ADDR_STATUS, 32'h0);
      cmp("status after reset", rd[7:0], 32'h09);
      $display("reset test done");
      end_of_test();
   end
endmodule
`default_nettype wire
